// ### include/dts_defines.vh
// Register offsets, field positions and reset values of the debug trigger sequencer
`ifndef DTS_DEFINES_VH
`define DTS_DEFINES_VH
`define DTS_OFF_CTRL     8'h00
`define DTS_OFF_STATUS   8'h04
`define DTS_OFF_MASK     8'h08
`define DTS_OFF_STATE    8'h0C
`define DTS_OFF_SCTL1    8'h10
`define DTS_OFF_SCTL2    8'h14
`define DTS_OFF_SCTL3    8'h18
`define DTS_OFF_COMPEN   8'h1C
`define DTS_OFF_IRQST    8'h20
`define DTS_OFF_IRQMSK   8'h24
`define DTS_OFF_CMP0     8'h40
`define DTS_OFF_CMP1     8'h44
`define DTS_OFF_CMP2     8'h48
`define DTS_OFF_CMP3     8'h4C
`define DTS_CTRL_ARM     7
`define DTS_CTRL_IMMEDIATE_TRIGGER_BIT    6
`define DTS_CTRL_BRK     4
`define DTS_CTRL_ALN_LO  0
`define DTS_CTRL_ALN_HI  1
`define DTS_CTRL_RANGE   2
`define DTS_ALN_BEGIN    2'h0
`define DTS_ALN_MID      2'h1
`define DTS_ALN_END      2'h2
`define DTS_ST_ARMED     2'h0
`define DTS_ST_S1        2'h1
`define DTS_ST_S2        2'h2
`define DTS_ST_S3        2'h3
`define DTS_SEQ_IDLE     3'h0
`define DTS_SEQ_S1       3'h1
`define DTS_SEQ_S2       3'h2
`define DTS_SEQ_S3       3'h3
`define DTS_SEQ_FINAL    3'h4
`define DTS_SCTL_RST     16'h0000
`define DTS_TRACE_CNT    8'h40
`define DTS_IRQ_IMMEDIATE_TRIGGER_BIT     0
`define DTS_IRQ_DISARM   1
`define DTS_IRQ_BRK      2
`endif

// ### rtl/dts_match_prio.v
// Comparator match priority encoder with range-mode suppression
module dts_match_prio #(
   parameter NCH = 4
) (
   // Raw matches, already qualified by channel enable
   input  wire [NCH-1:0] match_raw,
   input  wire           range_mode,
   // Per-channel next state select of the active state
   input  wire [4*NCH-1:0] sel_in,
   // Winner
   output reg            hit,
   output reg  [1:0]     chan,
   output reg  [3:0]     sel
);
   reg [NCH-1:0] m;
   integer i;
   always @* begin
      m    = match_raw;
      hit  = 1'b0;
      chan = 2'h0;
      sel  = 4'h0;
      // R11: A with C in range
      if (range_mode && m[0] && m[2]) begin
         m[2] = 1'b0;
      end
      // R9: lowest channel
      for (i = NCH - 1; i >= 0; i = i - 1) begin
         if (m[i]) begin
            hit  = 1'b1;
            chan = i[1:0];
            sel  = sel_in[4*i +: 4];
         end
      end
      // R10: final state wins, either select bit three or two leads there
      for (i = NCH - 1; i >= 0; i = i - 1) begin
         if (m[i] && (sel_in[4*i+3] || sel_in[4*i+2])) begin
            chan = i[1:0];
            sel  = sel_in[4*i +: 4];
         end
      end
   end
endmodule // dts_match_prio

// ### rtl/dts_trigger_seq.v
// Debug trigger qualification and state sequencer with AXI4-Lite registers
// Summary of operation
// R1: A forced comparator match moves the sequencer to its next state at once and sets the matching status flag.
// R2: The next state for each trigger comes from the state control setting of the active state.
// R3: Forced triggers are raised on the cycle the matching address is on the bus, ahead of a later tag hit.
// R4: Fetch matches tag the instruction, the core returns a tag hit at execution, which advances the sequencer.
// R5: Writing one to the immediate trigger bit under begin or mid alignment sends the sequencer to final state.
// R6: Under end alignment the immediate trigger disarms the module and ends the session.
// R7: With breakpoints on, the immediate trigger requests a breakpoint at once (end) or after tracing (begin, mid).
// R8: Of simultaneous triggers only the highest priority one acts; the rest are lost.
// R9: Among simultaneous comparator matches the lowest channel number wins.
// R10: A simultaneous match whose next state select leads to final state wins over all others.
// R11: In range mode a joint A and C match gives only the first match and suppresses the third.
// R12: A software arm write in the same cycle as a hardware disarm leaves armed cleared.
// R13: While disarmed all triggers but an immediate trigger in the arming write are ignored, and the sequencer holds until a write sets the arm bit.
`include "dts_defines.vh"
module dts_trigger_seq #(
   parameter NCH   = 4,
   parameter AW    = 16
) (
   // Clock and reset
   input  wire          core_clk,
   input  wire          rst_n,
   // Core address bus and instruction queue
   input  wire [AW-1:0] cpu_addr,
   input  wire          cpu_addr_valid,
   input  wire          cpu_fetch,
   input  wire [NCH-1:0] core_tag_hit,
   output reg  [NCH-1:0] tag_req,
   output reg           brk_req,
   output reg  [2:0]    seq_state,
   output reg           irq,
   // AXI4-Lite slave
   input  wire [7:0]    s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [7:0]    s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready
);
   // Registers
   reg [7:0]      ctrl_reg;
   reg [NCH-1:0]  flags_reg;
   reg [15:0]     sctl1_reg;
   reg [15:0]     sctl2_reg;
   reg [15:0]     sctl3_reg;
   reg [NCH-1:0]  comp_en_reg;
   reg [NCH-1:0]  tag_mode_reg;
   reg [2:0]      irq_st_reg;
   reg [2:0]      irq_msk_reg;
   reg [2:0]      state_reg;
   reg [2:0]      state_next;
   reg [AW-1:0]   cmp_addr_reg [0:NCH-1];
   reg            pend_brk_reg;
   reg [7:0]      trace_cnt_reg;
   reg            immediate_trigger_bit_flag_reg;
   // AXI write capture
   reg            aw_have_reg;
   reg            w_have_reg;
   reg [7:0]      aw_addr_reg;
   reg [31:0]     w_data_reg;
   reg [3:0]      w_strb_reg;
   wire           wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire           rd_go = s_axi_arvalid && s_axi_arready;
   wire           wr_ctrl = wr_go && aw_addr_reg == `DTS_OFF_CTRL && w_strb_reg[0];
   wire           armed = ctrl_reg[`DTS_CTRL_ARM];
   // Trigger write carries its own alignment and breakpoint enable
   wire [1:0]     align = w_data_reg[`DTS_CTRL_ALN_HI:`DTS_CTRL_ALN_LO];
   wire           imm_immediate_trigger_bit = wr_ctrl && w_data_reg[`DTS_CTRL_IMMEDIATE_TRIGGER_BIT];
   // Compare channels
   wire [NCH-1:0] addr_hit;
   wire [NCH-1:0] forced_m;
   wire [NCH-1:0] tagged_m;
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_cmp
         assign addr_hit[g] = armed && comp_en_reg[g] && cpu_addr_valid && cpu_addr == cmp_addr_reg[g];
         // R3: forced on address
         assign forced_m[g] = addr_hit[g] && !tag_mode_reg[g];
         // R4: tag hit returns
         assign tagged_m[g] = armed && comp_en_reg[g] && tag_mode_reg[g] && core_tag_hit[g];
      end
   endgenerate
   // Next-state select table of the active state
   reg [15:0] sctl_cur;
   always @* begin
      // R2: select by state
      case (state_reg)
         `DTS_SEQ_S1: sctl_cur = sctl1_reg;
         `DTS_SEQ_S2: sctl_cur = sctl2_reg;
         `DTS_SEQ_S3: sctl_cur = sctl3_reg;
         default:     sctl_cur = sctl1_reg;
      endcase
   end
   wire        f_hit;
   wire [1:0]  f_chan;
   wire [3:0]  f_sel;
   wire        t_hit;
   wire [1:0]  t_chan;
   wire [3:0]  t_sel;
   dts_match_prio #(.NCH(NCH)) u_forced (
      .match_raw  (forced_m),
      .range_mode (ctrl_reg[`DTS_CTRL_RANGE]),
      .sel_in     (sctl_cur),
      .hit        (f_hit),
      .chan       (f_chan),
      .sel        (f_sel)
   );
   dts_match_prio #(.NCH(NCH)) u_tagged (
      .match_raw  (tagged_m),
      .range_mode (ctrl_reg[`DTS_CTRL_RANGE]),
      .sel_in     (sctl_cur),
      .hit        (t_hit),
      .chan       (t_chan),
      .sel        (t_sel)
   );
   // Sequencer decision
   reg        hw_disarm;
   reg        set_flag;
   reg [1:0]  flag_chan;
   reg        brk_now;
   reg        brk_defer;
   always @* begin
      state_next = state_reg;
      hw_disarm  = 1'b0;
      set_flag   = 1'b0;
      flag_chan  = 2'h0;
      brk_now    = 1'b0;
      brk_defer  = 1'b0;
      // R8: one trigger acts
      if (imm_immediate_trigger_bit && (armed || w_data_reg[`DTS_CTRL_ARM])) begin
         if (align == `DTS_ALN_END) begin
            // R6: end alignment disarm
            hw_disarm  = 1'b1;
            state_next = `DTS_SEQ_IDLE;
            // R7: immediate breakpoint
            brk_now    = w_data_reg[`DTS_CTRL_BRK];
         end else begin
            // R5: straight to final
            state_next = `DTS_SEQ_FINAL;
            brk_defer  = w_data_reg[`DTS_CTRL_BRK];
         end
      end else if (!armed || state_reg == `DTS_SEQ_FINAL || state_reg == `DTS_SEQ_IDLE) begin
         // R13: hold while disarmed
         state_next = state_reg;
      end else if (f_hit || t_hit) begin
         // R1: forced advance and flag
         set_flag  = 1'b1;
         flag_chan = f_hit ? f_chan : t_chan;
         case (f_hit ? f_sel[3:2] : t_sel[3:2])
            2'h0: state_next = {1'b0, (f_hit ? f_sel[1:0] : t_sel[1:0])};
            default: state_next = `DTS_SEQ_FINAL;
         endcase
         if (state_next == `DTS_SEQ_IDLE) begin
            state_next = state_reg;
         end
         if (state_next == `DTS_SEQ_FINAL) begin
            brk_defer = ctrl_reg[`DTS_CTRL_BRK];
         end
      end
   end
   wire trace_done = state_reg == `DTS_SEQ_FINAL && trace_cnt_reg == 8'h00;
   wire [2:0] irq_ev = {brk_now || (pend_brk_reg && trace_done), hw_disarm || trace_done, set_flag || imm_immediate_trigger_bit};
   wire rd_irqst = rd_go && s_axi_araddr == `DTS_OFF_IRQST;
   wire rd_stat  = rd_go && s_axi_araddr == `DTS_OFF_STATUS;
   reg [31:0] rd_mux;
   always @* begin
      case (s_axi_araddr)
         `DTS_OFF_CTRL:   rd_mux = {24'h00_0000, ctrl_reg};
         `DTS_OFF_STATUS: rd_mux = {27'h000_0000, immediate_trigger_bit_flag_reg, flags_reg};
         `DTS_OFF_MASK:   rd_mux = {28'h000_0000, tag_mode_reg};
         `DTS_OFF_STATE:  rd_mux = {29'h000_0000, state_reg};
         `DTS_OFF_SCTL1:  rd_mux = {16'h0000, sctl1_reg};
         `DTS_OFF_SCTL2:  rd_mux = {16'h0000, sctl2_reg};
         `DTS_OFF_SCTL3:  rd_mux = {16'h0000, sctl3_reg};
         `DTS_OFF_COMPEN: rd_mux = {28'h000_0000, comp_en_reg};
         `DTS_OFF_IRQST:  rd_mux = {29'h000_0000, irq_st_reg};
         `DTS_OFF_IRQMSK: rd_mux = {29'h000_0000, irq_msk_reg};
         `DTS_OFF_CMP0, `DTS_OFF_CMP1, `DTS_OFF_CMP2, `DTS_OFF_CMP3:
            rd_mux = {{(32-AW){1'b0}}, cmp_addr_reg[s_axi_araddr[3:2]]};
         default:         rd_mux = 32'h0000_0000;
      endcase
   end
   integer k;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'h0;
         s_axi_rdata   <= 32'h0000_0000;
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= 32'h0000_0000;
         w_strb_reg    <= 4'h0;
         ctrl_reg      <= 8'h00;
         flags_reg     <= {NCH{1'b0}};
         immediate_trigger_bit_flag_reg <= 1'b0;
         sctl1_reg     <= `DTS_SCTL_RST;
         sctl2_reg     <= `DTS_SCTL_RST;
         sctl3_reg     <= `DTS_SCTL_RST;
         comp_en_reg   <= {NCH{1'b0}};
         tag_mode_reg  <= {NCH{1'b0}};
         irq_st_reg    <= 3'h0;
         irq_msk_reg   <= 3'h0;
         state_reg     <= `DTS_SEQ_IDLE;
         pend_brk_reg  <= 1'b0;
         trace_cnt_reg <= 8'h00;
         tag_req       <= {NCH{1'b0}};
         brk_req       <= 1'b0;
         seq_state     <= `DTS_SEQ_IDLE;
         irq           <= 1'b0;
         for (k = 0; k < NCH; k = k + 1) begin
            cmp_addr_reg[k] <= {AW{1'b0}};
         end
      end else begin
         // Write channel capture, either order
         s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg > `DTS_OFF_CMP3) ? 2'h2 : 2'h0;
            case (aw_addr_reg)
               `DTS_OFF_SCTL1:  sctl1_reg   <= w_data_reg[15:0];
               `DTS_OFF_SCTL2:  sctl2_reg   <= w_data_reg[15:0];
               `DTS_OFF_SCTL3:  sctl3_reg   <= w_data_reg[15:0];
               `DTS_OFF_MASK:   tag_mode_reg <= w_data_reg[NCH-1:0];
               `DTS_OFF_COMPEN: comp_en_reg <= w_data_reg[NCH-1:0];
               `DTS_OFF_IRQMSK: irq_msk_reg <= w_data_reg[2:0];
               `DTS_OFF_CMP0, `DTS_OFF_CMP1, `DTS_OFF_CMP2, `DTS_OFF_CMP3:
                  cmp_addr_reg[aw_addr_reg[3:2]] <= w_data_reg[AW-1:0];
               default: ;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // Read channel
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (s_axi_araddr > `DTS_OFF_CMP3) ? 2'h2 : 2'h0;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         // R12: disarm wins
         if (wr_ctrl) begin
            ctrl_reg <= {w_data_reg[7] && !hw_disarm && !trace_done, 1'b0, w_data_reg[5:0]};
         end else if (hw_disarm || trace_done) begin
            ctrl_reg[`DTS_CTRL_ARM] <= 1'b0;
         end
         // Arming without an immediate trigger starts the sequencer in state one
         if (wr_ctrl && w_data_reg[`DTS_CTRL_ARM] && !armed && !imm_immediate_trigger_bit) begin
            state_reg     <= `DTS_SEQ_S1;
            flags_reg     <= {NCH{1'b0}};
            immediate_trigger_bit_flag_reg <= 1'b0;
         end else if (trace_done && !imm_immediate_trigger_bit) begin
            state_reg <= `DTS_SEQ_IDLE;
         end else begin
            state_reg <= state_next;
         end
         if (state_next == `DTS_SEQ_FINAL && state_reg != `DTS_SEQ_FINAL) begin
            trace_cnt_reg <= `DTS_TRACE_CNT;
         end else if (state_reg == `DTS_SEQ_FINAL && trace_cnt_reg != 8'h00) begin
            trace_cnt_reg <= trace_cnt_reg - 8'h01;
         end
         // R1: status flag set
         if (set_flag) begin
            flags_reg[flag_chan] <= 1'b1;
         end
         if (imm_immediate_trigger_bit) begin
            immediate_trigger_bit_flag_reg <= 1'b1;
         end
         // R7: deferred breakpoint
         if (brk_defer) begin
            pend_brk_reg <= 1'b1;
         end else if (trace_done || !armed) begin
            pend_brk_reg <= 1'b0;
         end
         brk_req <= brk_now || (pend_brk_reg && trace_done);
         // R4: tag fetched opcodes
         tag_req   <= addr_hit & tag_mode_reg & {NCH{cpu_fetch}};
         seq_state <= state_reg;
         irq_st_reg <= (rd_irqst ? 3'h0 : irq_st_reg) | irq_ev;
         irq        <= |(irq_st_reg & irq_msk_reg);
      end
   end
endmodule // dts_trigger_seq

// ### tb/dts_cpu_model.sv
// Core model: drives bus addresses and returns tag hits at execution
module dts_cpu_model #(
   parameter int LAT = 3
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Tag requests from the debug logic
   input  wire logic [3:0]  tag_req,
   // Address bus and tag hits
   output logic      [15:0] cpu_addr,
   output logic             cpu_addr_valid,
   output logic             cpu_fetch,
   output logic      [3:0]  core_tag_hit
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4*LAT-1:0] pipe;
   initial begin
      cpu_addr = 16'h0000;
      cpu_addr_valid = 1'b0;
      cpu_fetch = 1'b0;
   end
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) pipe <= '0;
      else pipe <= {pipe[4*LAT-5:0], tag_req};
   end
   assign core_tag_hit = pipe[4*LAT-1 -: 4];
   // One bus cycle, then the released address is scrambled
   task automatic access(input logic [15:0] ad, input logic f);
      @(posedge core_clk);
      cpu_addr <= ad;
      cpu_addr_valid <= 1'b1;
      cpu_fetch <= f;
      @(posedge core_clk);
      cpu_addr <= ~ad;
      cpu_addr_valid <= 1'b0;
      cpu_fetch <= 1'b0;
   endtask
endmodule // dts_cpu_model

// ### tb/dts_trigger_chk.sv
// Port checker for the debug trigger sequencer
module dts_trigger_chk #(
   parameter int NCH = 4
) (
   // Clock and reset
   input wire logic           core_clk,
   input wire logic           rst_n,
   // Core side
   input wire logic           cpu_addr_valid,
   input wire logic           cpu_fetch,
   input wire logic [NCH-1:0] tag_req,
   input wire logic           brk_req,
   input wire logic [2:0]     seq_state,
   // Bus handshakes
   input wire logic           s_axi_arvalid,
   input wire logic           s_axi_arready,
   input wire logic           s_axi_rvalid,
   input wire logic           s_axi_rready,
   input wire logic           s_axi_bvalid,
   input wire logic           s_axi_bready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   tag_cause_a: assert property (|tag_req |-> $past(cpu_addr_valid && cpu_fetch))
      else $error("tag request without a fetch");
   brk_pulse_a: assert property (brk_req |=> !brk_req)
      else $error("breakpoint request longer than one cycle");
   final_hold_a: assert property ($rose(seq_state == 3'h4) |-> (seq_state == 3'h4) [*8])
      else $error("final state left early");
   trace_end_a: assert property ($rose(seq_state == 3'h4) |-> ##[62:68] seq_state == 3'h0)
      else $error("trace did not end in time");
   state_range_a: assert property (seq_state <= 3'h4)
      else $error("sequencer state out of range");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer held after handshake");
   wr_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer held after handshake");
endmodule // dts_trigger_chk
bind dts_trigger_seq dts_trigger_chk #(.NCH(NCH)) chk (.core_clk, .rst_n, .cpu_addr_valid, .cpu_fetch,
   .tag_req, .brk_req, .seq_state, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_bvalid, .s_axi_bready);

// ### tb/tb.sv
// Self-checking bench for the debug trigger sequencer
`include "dts_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LIM = 200;
   logic        core_clk = 1'b0, rst_n = 1'b0;
   logic [15:0] cpu_addr, a, b;
   logic        cpu_addr_valid, cpu_fetch, brk_req, irq;
   logic [3:0]  core_tag_hit, tag_req, tag_seen = 4'h0;
   logic [2:0]  seq_state;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [33:0] rq[$], e;
   logic [1:0]  bq[$];
   int          failures = 0, cmp_count = 0, brk_cnt = 0, seed = 74789, k;

   dts_trigger_seq #(.NCH(4), .AW(16)) uut (.core_clk, .rst_n, .cpu_addr, .cpu_addr_valid, .cpu_fetch,
      .core_tag_hit, .tag_req, .brk_req, .seq_state, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   dts_cpu_model #(.LAT(3)) cpu (.core_clk, .rst_n, .tag_req, .cpu_addr, .cpu_addr_valid, .cpu_fetch,
      .core_tag_hit);

   initial forever #50 core_clk = ~core_clk;

   task automatic chk(input string n, input logic [33:0] ex, input logic [33:0] g);
      cmp_count++;
      if (g !== ex) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", n, ex, g);
      end
   endtask
   task automatic results();
      if (failures == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic bound(input int n);
      if (n >= LIM) begin
         failures++;
         results();
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r = 2'b00);
      int n = 0;
      bq.push_back(r);
      @(posedge core_clk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < LIM);
      s_axi_bready <= 1'b0;
      bound(n);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [33:0] ex);
      int n = 0;
      rq.push_back(ex);
      @(posedge core_clk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < LIM);
      s_axi_rready <= 1'b0;
      bound(n);
   endtask
   task automatic until_state(input logic [2:0] s);
      int n = 0;
      while (seq_state !== s && n < LIM) begin
         @(posedge core_clk);
         n++;
      end
      bound(n);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Watch answers; an error read compares its response only
   always @(posedge core_clk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         e = rq.pop_front();
         chk("read", e, {s_axi_rresp, e[33] ? e[31:0] : s_axi_rdata});
      end
      if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
      if (|tag_req) tag_seen <= tag_req;
      if (brk_req) brk_cnt <= brk_cnt + 1;
   end

   initial begin
      a = 16'($random(seed));
      b = ~a;
      settle(12);
      rst_n <= 1'b1;
      rd(`DTS_OFF_CTRL, 34'h0);
      rd(`DTS_OFF_STATUS, 34'h0);
      rd(8'h50, {2'b10, 32'h0000_0000});
      wr(8'h50, 32'h0000_0001, 2'b10);
      rd(8'h28, 34'h0);
      // Channels 0 and 2 share one address, 1 and 3 the other
      for (k = 0; k < 4; k++) wr(8'h40 + 8'(4 * k), {16'h0000, k[0] ? b : a});
      wr(`DTS_OFF_COMPEN, 32'h0000_000f);
      wr(`DTS_OFF_SCTL1, 32'h0000_0802);
      wr(`DTS_OFF_SCTL2, 32'h0000_8030);
      wr(`DTS_OFF_CTRL, 32'h0000_0084);
      settle(2);
      chk("state", 34'h1, seq_state);
      cpu.access(a, 1'b0);
      settle(2);
      chk("state", 34'h2, seq_state);
      rd(`DTS_OFF_STATUS, 34'h1);
      chk("irq", 34'h0, irq);
      wr(`DTS_OFF_IRQMSK, 32'h0000_0001);
      settle(2);
      chk("irq", 34'h1, irq);
      rd(`DTS_OFF_IRQST, 34'h1);
      settle(3);
      chk("irq", 34'h0, irq);
      cpu.access(b, 1'b0);
      settle(2);
      chk("state", 34'h4, seq_state);
      rd(`DTS_OFF_STATUS, 34'h9);
      until_state(3'h0);
      rd(`DTS_OFF_CTRL, 34'h4);
      cpu.access(a, 1'b0);
      settle(2);
      chk("state", 34'h0, seq_state);
      // Channel 0 tagged and the only one enabled
      wr(`DTS_OFF_MASK, 32'h0000_0001);
      wr(`DTS_OFF_COMPEN, 32'h0000_0001);
      wr(`DTS_OFF_CTRL, 32'h0000_0080);
      cpu.access(a, 1'b1);
      settle(3);
      chk("state", 34'h1, seq_state);
      chk("tag", 34'h1, tag_seen);
      until_state(3'h2);
      chk("state", 34'h2, seq_state);
      // Immediate trigger under begin, then mid alignment
      for (k = 0; k < 2; k++) begin
         wr(`DTS_OFF_CTRL, 32'h0000_00d0 | k);
         settle(2);
         chk("state", 34'h4, seq_state);
         chk("brk", k, brk_cnt);
         until_state(3'h0);
         settle(2);
         chk("brk", k + 1, brk_cnt);
      end
      // Arm and trigger in one write under end alignment
      wr(`DTS_OFF_CTRL, 32'h0000_00d2);
      settle(2);
      chk("brk", 34'h3, brk_cnt);
      chk("state", 34'h0, seq_state);
      rd(`DTS_OFF_CTRL, 34'h12);
      results();
   end
endmodule // tb
